// file: core/abce_pkg.sv
// Contract
// R1: emulator pulls latch strobe low during reset
// R2: strobe held low through release enters emulation
// R3: only plain reset leaves emulation mode
// R4: emulation: strobes, ports 1-3 weak, others float
// R5: latch strobe demultiplexes port 0 address/data
// R6: free-running latch strobe, osc/6 or osc/3
// R7: latch-output-control bit suppresses free strobe
// R8: suppressed strobe still pulses on external cycles
// R9: suppressed strobe pin left weakly pulled high
// R10: read/write strobes 6 or 30 clocks
// R11: two-bit field sizes expanded RAM 256-1024
// R12: external-select bit routes data moves outward
// R13: software never sets reserved bits 6, 4
// R14: reset value 0x0c, reserved bits undefined
// R15: strobe level sampled first edge after reset
package abce_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] AUX_OFFSET  = 8'h8e;
  localparam logic [7:0] STAT_OFFSET = 8'hf0;
  localparam logic [7:0] AUX_RESET   = 8'h0c;
  // reserved bits are not stored and read as zero
  localparam logic [7:0] AUX_WMASK   = 8'haf;
  localparam int         STAT_EMU    = 0;
  localparam int         STAT_RD     = 1;
  localparam int         STAT_WR     = 2;

  // ************************************************************
  // timing, in oscillator clock periods; strobe counter width and RAM size unit
  // ************************************************************
  localparam int         ALE_DIV_X1  = 6;
  localparam int         ALE_DIV_X2  = 3;
  localparam int         STB_SHORT   = 6;
  localparam int         STB_LONG    = 30;
  localparam int         STB_CW      = 5;
  localparam int         EXPANDED_INTERNAL_RAM_UNIT   = 256;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic       pullup_disable;
    logic       rsv6;
    logic       strobe_stretch;
    logic       rsv4;
    logic       xram_size_hi;
    logic       xram_size_lo;
    logic       ext_data_select;
    logic       latch_output_ctrl;
  } abce_aux_s;

  typedef struct packed {
    logic        ext_cycle;
    logic        ext_fetch;
    logic        xmove_req;
    logic        xmove_we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } abce_core_s;

  typedef struct packed {
    logic port0_float;
    logic port123_weak;
    logic i2_float;
    logic osc_active;
  } abce_pins_s;

  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_EMU   = 2'b10
  } abce_mode_e;

endpackage

// file: core/abce_strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none
module abce_strobe_timer #(
  parameter int CW = 5
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          start_i,
  input  wire logic [CW-1:0] len_i,
  output logic               strobe_n_o,
  output logic               busy_o
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] len_r;
  logic [CW-1:0] run_r;

  // ************************************************************
  // pulse timer
  // ************************************************************
  // a start while busy is dropped; the caller sees busy_o
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      strobe_n_o <= 1'b1;
      cnt_r      <= '0;
    end else if (strobe_n_o && start_i) begin
      strobe_n_o <= 1'b0;
      cnt_r      <= len_i - 1'b1;
    end else if (!strobe_n_o) begin
      if (cnt_r == '0) begin
        strobe_n_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign busy_o = !strobe_n_o;

  // ************************************************************
  // checks
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      run_r <= '0;
      len_r <= '0;
    end else begin
      if (strobe_n_o && start_i) begin
        len_r <= len_i;
      end
      run_r <= strobe_n_o ? '0 : run_r + 1'b1;
    end
  end

  property p_stb_len;
    @(posedge core_clk_i) disable iff (rst_i)
    $rose(strobe_n_o) |-> run_r == len_r;
  endproperty
  a_stb_len: assert property (p_stb_len) else $error("strobe length wrong"); // R10

endmodule
`default_nettype wire

// file: core/abce_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module abce_top (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // register port
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [7:0]         reg_wdata_i,
  input  wire logic               reg_we_i,
  input  wire logic               reg_re_i,
  output logic      [7:0]         reg_rdata_o,
  // core side
  input  wire logic               double_speed_i,
  input  wire abce_pkg::abce_core_s core_i,
  output logic                    xmove_ready_o,
  output logic                    xram_int_o,
  output logic      [9:0]         xram_addr_o,
  output logic                    pullup_disable_o,
  output logic                    emulation_entry_mode_o,
  output abce_pkg::abce_pins_s    pins_o,
  // address-latch strobe pin
  input  wire logic               ale_i,
  output logic                    ale_o,
  output logic                    ale_oe_o,
  output logic                    ale_pu_o,
  // program-store strobe pin
  input  wire logic               prog_store_strobe_i,
  output logic                    prog_store_strobe_o,
  output logic                    prog_store_strobe_oe_o,
  output logic                    prog_store_strobe_pu_o,
  // port 0 and read/write strobes
  output logic      [7:0]         p0_o,
  output logic                    p0_oe_o,
  output logic      [7:0]         p2_o,
  output logic                    rd_n_o,
  output logic                    wr_n_o,
  output logic                    rdwr_oe_o
);

  abce_pkg::abce_aux_s  aux_r;
  abce_pkg::abce_mode_e mode_r;
  logic [1:0]           ale_s_r;
  logic [1:0]           prog_store_strobe_s_r;
  logic                 prog_store_strobe_hi_r;
  logic                 run;
  logic [2:0]           phase_r;
  logic                 phase0;
  logic                 emu;
  logic                 xint;
  logic [1:0]           stb_start;
  logic [1:0]           stb_n;
  logic [1:0]           stb_busy;
  logic [abce_pkg::STB_CW-1:0] stb_len;

  // ************************************************************
  // decoding
  // ************************************************************
  function automatic logic [10:0] expanded_internal_ram_size(input abce_pkg::abce_aux_s a);
    // widen before the add so the largest size code does not wrap to zero
    expanded_internal_ram_size = (11'({a.xram_size_hi, a.xram_size_lo}) + 11'd1) *
                11'(abce_pkg::EXPANDED_INTERNAL_RAM_UNIT);
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    ale_s_r  <= {ale_s_r[0], ale_i};
    prog_store_strobe_s_r <= {prog_store_strobe_s_r[0], prog_store_strobe_i};
  end

  // ************************************************************
  // emulation entry
  // ************************************************************
  // the program-store strobe must be seen high while reset is held
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prog_store_strobe_hi_r <= prog_store_strobe_s_r[1]; // R1
    end
  end

  // reset always returns to MODE_RESET, so only a reset leaves emulation
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_r <= abce_pkg::MODE_RESET; // R3
    end else begin
      unique case (mode_r)
        abce_pkg::MODE_RESET: begin
          mode_r <= (!ale_s_r[1] && prog_store_strobe_hi_r) ? abce_pkg::MODE_EMU // R2 R15
                                               : abce_pkg::MODE_RUN;
        end
        abce_pkg::MODE_RUN: begin
          mode_r <= abce_pkg::MODE_RUN;
        end
        abce_pkg::MODE_EMU: begin
          mode_r <= abce_pkg::MODE_EMU;
        end
        default: begin
          mode_r <= abce_pkg::MODE_RESET;
        end
      endcase
    end
  end

  assign emu = (mode_r == abce_pkg::MODE_EMU);
  assign emulation_entry_mode_o = emu;
  // latch, program-store and port 0 pins stay released on the decision cycle so an emulator is never fought
  assign run = (mode_r == abce_pkg::MODE_RUN);

  // pin states while the emulator owns the board
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else begin
      pins_o.port0_float  <= emu; // R4
      pins_o.port123_weak <= emu;
      pins_o.i2_float     <= emu;
      pins_o.osc_active   <= 1'b1;
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      aux_r <= abce_pkg::AUX_RESET; // R14
    end else if (reg_we_i && reg_addr_i == abce_pkg::AUX_OFFSET) begin
      aux_r <= reg_wdata_i & abce_pkg::AUX_WMASK; // R13
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_re_i && reg_addr_i == abce_pkg::AUX_OFFSET) begin
      reg_rdata_o <= aux_r;
    end else if (reg_re_i && reg_addr_i == abce_pkg::STAT_OFFSET) begin
      reg_rdata_o <= '0;
      reg_rdata_o[abce_pkg::STAT_EMU] <= emu;
      reg_rdata_o[abce_pkg::STAT_RD]  <= stb_busy[0];
      reg_rdata_o[abce_pkg::STAT_WR]  <= stb_busy[1];
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // polarity of this bit is unsettled, so it is passed on as stored
  assign pullup_disable_o = aux_r.pullup_disable;

  // ************************************************************
  // address-latch strobe
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      phase_r <= '0;
    end else if (phase_r >= 3'(double_speed_i ? abce_pkg::ALE_DIV_X2 - 1
                                              : abce_pkg::ALE_DIV_X1 - 1)) begin
      phase_r <= '0; // R6
    end else begin
      phase_r <= phase_r + 3'd1;
    end
  end

  assign phase0 = (phase_r == 3'd0);

  // not driven during reset, so an emulator can pull the pin low
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run) begin
      ale_o    <= 1'b0;
      ale_oe_o <= 1'b0; // R4
      ale_pu_o <= 1'b1;
    end else if (!aux_r.latch_output_ctrl) begin
      ale_o    <= phase0; // R6
      ale_oe_o <= 1'b1;
      ale_pu_o <= 1'b0;
    end else begin
      ale_o    <= phase0 && core_i.ext_cycle; // R7 R8
      ale_oe_o <= core_i.ext_cycle;
      ale_pu_o <= !core_i.ext_cycle; // R9
    end
  end

  // ************************************************************
  // port 0 demultiplex, program-store strobe
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run) begin
      p0_o    <= '0;
      p0_oe_o <= 1'b0;
      p2_o    <= '0;
    end else begin
      p0_o    <= phase0 ? core_i.addr[7:0] : core_i.wdata; // R5
      p0_oe_o <= core_i.ext_cycle;
      p2_o    <= core_i.addr[15:8];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || !run) begin
      prog_store_strobe_o    <= 1'b1;
      prog_store_strobe_oe_o <= 1'b0; // R4
      prog_store_strobe_pu_o <= 1'b1;
    end else begin
      prog_store_strobe_o    <= !(core_i.ext_fetch && !phase0);
      prog_store_strobe_oe_o <= 1'b1;
      prog_store_strobe_pu_o <= 1'b0;
    end
  end

  // ************************************************************
  // data moves and read/write strobes
  // ************************************************************
  assign xint = !aux_r.ext_data_select && // R12
                (core_i.addr < 16'(expanded_internal_ram_size(aux_r))); // R11

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xram_int_o  <= 1'b0;
      xram_addr_o <= '0;
    end else if (core_i.xmove_req && xmove_ready_o) begin
      xram_int_o  <= xint;
      xram_addr_o <= core_i.addr[9:0];
    end else begin
      xram_int_o  <= 1'b0;
    end
  end

  assign xmove_ready_o = !(stb_busy[0] || stb_busy[1]) && !emu;
  assign stb_len = aux_r.strobe_stretch ? abce_pkg::STB_CW'(abce_pkg::STB_LONG) // R10
                                        : abce_pkg::STB_CW'(abce_pkg::STB_SHORT);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_stb
      assign stb_start[gi] = core_i.xmove_req && xmove_ready_o && !xint &&
                             (core_i.xmove_we == (gi == 1));
      abce_strobe_timer #(
        .CW (abce_pkg::STB_CW)
      ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .start_i    (stb_start[gi]),
        .len_i      (stb_len),
        .strobe_n_o (stb_n[gi]),
        .busy_o     (stb_busy[gi])
      );
    end
  endgenerate

  assign rd_n_o    = stb_n[0];
  assign wr_n_o    = stb_n[1];
  assign rdwr_oe_o = !emu && !rst_i;

  // ************************************************************
  // checks
  // ************************************************************
  property p_emu_entry;
    @(posedge core_clk_i) disable iff (rst_i)
    (mode_r == abce_pkg::MODE_RESET && !ale_s_r[1] && prog_store_strobe_hi_r) |=> emu;
  endproperty
  a_emu_entry: assert property (p_emu_entry) else $error("emulation not entered"); // R2

  property p_emu_normal;
    @(posedge core_clk_i) disable iff (rst_i)
    (mode_r == abce_pkg::MODE_RESET && ale_s_r[1]) |=> mode_r == abce_pkg::MODE_RUN;
  endproperty
  a_emu_normal: assert property (p_emu_normal) else $error("normal start missed"); // R15

  property p_emu_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    emu |=> emu;
  endproperty
  a_emu_hold: assert property (p_emu_hold) else $error("emulation left without reset"); // R3

  property p_emu_pins;
    @(posedge core_clk_i) disable iff (rst_i)
    emu ##1 emu |-> !ale_oe_o && ale_pu_o && !prog_store_strobe_oe_o && pins_o.port0_float;
  endproperty
  a_emu_pins: assert property (p_emu_pins) else $error("pins driven in emulation"); // R4

  property p_ale_rate;
    @(posedge core_clk_i) disable iff (rst_i)
    (ale_o && ale_oe_o && !aux_r.latch_output_ctrl && !double_speed_i && !emu)
      |=> (!ale_o)[*5] ##1 (ale_o || $past(aux_r.latch_output_ctrl));
  endproperty
  a_ale_rate: assert property (p_ale_rate) else $error("latch strobe rate wrong"); // R6

  property p_ale_quiet;
    @(posedge core_clk_i) disable iff (rst_i)
    ale_oe_o && $past(aux_r.latch_output_ctrl) |-> $past(core_i.ext_cycle);
  endproperty
  a_ale_quiet: assert property (p_ale_quiet) else $error("latch strobe not suppressed"); // R7

  property p_ale_pull;
    @(posedge core_clk_i) disable iff (rst_i)
    !ale_oe_o |-> ale_pu_o;
  endproperty
  a_ale_pull: assert property (p_ale_pull) else $error("idle latch pin not pulled"); // R9

  property p_aux_reset;
    @(posedge core_clk_i) disable iff (rst_i)
    $past(rst_i) |-> aux_r == abce_pkg::AUX_RESET;
  endproperty
  a_aux_reset: assert property (p_aux_reset) else $error("aux reset value wrong"); // R14

  property p_ext_route;
    @(posedge core_clk_i) disable iff (rst_i)
    (core_i.xmove_req && xmove_ready_o && aux_r.ext_data_select)
      |=> !xram_int_o && (!rd_n_o || !wr_n_o);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("move not sent outward"); // R12

  property p_expanded_internal_ram_size;
    @(posedge core_clk_i) disable iff (rst_i)
    (core_i.xmove_req && xmove_ready_o && !aux_r.ext_data_select &&
     core_i.addr < 16'(expanded_internal_ram_size(aux_r))) |=> xram_int_o && rd_n_o && wr_n_o;
  endproperty
  a_expanded_internal_ram_size: assert property (p_expanded_internal_ram_size) else $error("internal ram miss"); // R11

endmodule
`default_nettype wire

// file: dv/abce_bench.sv
`timescale 1ns/1ps
`default_nettype none
module abce_bench;
  logic                 core_clk_i, rst_i, reg_we_i, reg_re_i, double_speed_i, emu_hold;
  logic [7:0]           reg_addr_i, reg_wdata_i, reg_rdata_o, p0_o, p2_o, d;
  abce_pkg::abce_core_s core_v;
  abce_pkg::abce_pins_s pins_o;
  logic                 xmove_ready_o, xram_int_o, pullup_disable_o, emu_o;
  logic [9:0]           xram_addr_o;
  logic                 ale_i, ale_o, ale_oe_o, ale_pu_o, ps_i, ps_o, ps_oe_o, ps_pu_o;
  logic                 p0_oe_o, rd_n_o, wr_n_o, rdwr_oe_o;
  int                   n_mismatch, total_checks, cyc, g, lo, in;

  abce_top abce_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .double_speed_i(double_speed_i), .core_i(core_v),
    .xmove_ready_o(xmove_ready_o), .xram_int_o(xram_int_o), .xram_addr_o(xram_addr_o),
    .pullup_disable_o(pullup_disable_o), .emulation_entry_mode_o(emu_o), .pins_o(pins_o),
    .ale_i(ale_i), .ale_o(ale_o), .ale_oe_o(ale_oe_o), .ale_pu_o(ale_pu_o),
    .prog_store_strobe_i(ps_i), .prog_store_strobe_o(ps_o),
    .prog_store_strobe_oe_o(ps_oe_o), .prog_store_strobe_pu_o(ps_pu_o), .p0_o(p0_o),
    .p0_oe_o(p0_oe_o), .p2_o(p2_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .rdwr_oe_o(rdwr_oe_o));

  abce_mem_model abce_mem_model_i (.core_clk_i(core_clk_i), .emu_hold_i(emu_hold),
    .ale_drv_i(ale_o), .ale_oe_i(ale_oe_o), .ale_pu_i(ale_pu_o), .prog_store_strobe_drv_i(ps_o),
    .prog_store_strobe_oe_i(ps_oe_o), .prog_store_strobe_pu_i(ps_pu_o), .ale_pin_o(ale_i), .prog_store_strobe_pin_o(ps_i));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk_bit(string nm, logic e, logic s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic chk_val(string nm, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_we_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i    <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i   <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // emulator pull is kept up for three cycles after release
  task automatic do_reset(logic emu, logic ds);
    @(posedge core_clk_i);
    rst_i          <= 1'b1;
    emu_hold       <= emu;
    double_speed_i <= ds;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    emu_hold <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask
  // one data move; counts strobe-low cycles and internal pulses
  task automatic move(logic we, logic [15:0] a);
    @(posedge core_clk_i);
    core_v.xmove_req <= 1'b1;
    core_v.xmove_we  <= we;
    core_v.addr      <= a;
    @(posedge core_clk_i);
    core_v.xmove_req <= 1'b0;
    lo = 0;
    in = 0;
    repeat (36) begin
      #1;
      if ((we ? wr_n_o : rd_n_o) === 1'b0) lo++;
      if (xram_int_o === 1'b1) begin
        in++;
        chk_val("xram addr", a[9:0], xram_addr_o);
      end
      @(posedge core_clk_i);
    end
  endtask
  task automatic ale_gap();
    int k;
    k = 0;
    #1;
    while (ale_o !== 1'b1 && k < 20) begin
      @(posedge core_clk_i);
      #1 k++;
    end
    g = 0;
    do begin
      @(posedge core_clk_i);
      #1 g++;
    end while (ale_o !== 1'b1 && g < 20);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    rd(8'h8e);
    chk_val("aux reset", 16'h000c, d);
    rd(8'h8f);
    chk_val("unmapped", 16'h0000, d);
    wr(8'h8e, 8'hff);
    rd(8'h8e);
    chk_val("aux reserved", 16'h00af, d);
    chk_bit("pullup disable", 1'b1, pullup_disable_o);
    wr(8'h8e, 8'h0c);
  endtask
  task automatic t_moves();
    wr(8'h8e, 8'h0e);
    move(1'b0, 16'h0010);
    chk_val("short read", 16'd6, lo[15:0]);
    wr(8'h8e, 8'h2e);
    move(1'b1, 16'h0010);
    chk_val("long write", 16'd30, lo[15:0]);
    for (int s = 0; s < 4; s++) begin
      wr(8'h8e, 8'(s << 2));
      move(1'b0, 16'(256 * (s + 1) - 1));
      chk_val("int pulses", 16'd1, in[15:0]);
      chk_val("int strobe", 16'd0, lo[15:0]);
      move(1'b0, 16'(256 * (s + 1)));
      chk_val("ext strobe", 16'd6, lo[15:0]);
    end
    move(1'b0, 16'h0800);
    chk_val("high addr ext", 16'd6, lo[15:0]);
    wr(8'h8e, 8'h0c);
  endtask
  task automatic t_ale();
    ale_gap();
    chk_val("ale period", 16'd6, g[15:0]);
    chk_bit("ale driven", 1'b1, ale_oe_o);
    wr(8'h8e, 8'h01);
    repeat (3) @(posedge core_clk_i);
    in = 0;
    repeat (12) begin
      @(posedge core_clk_i);
      #1 if (ale_oe_o !== 1'b0 || ale_pu_o !== 1'b1) in++;
    end
    chk_val("ale quiet", 16'd0, in[15:0]);
    @(posedge core_clk_i);
    core_v.addr      <= 16'h12a5;
    core_v.ext_cycle <= 1'b1;
    core_v.ext_fetch <= 1'b1;
    in = 0;
    lo = 0;
    repeat (14) begin
      @(posedge core_clk_i);
      #1 if (ale_o === 1'b1 && ale_oe_o === 1'b1) begin
        in++;
        chk_val("p0 addr", 16'h00a5, p0_o);
      end
      if (ps_o === 1'b0) lo++;
    end
    chk_bit("ale on ext", 1'b1, in >= 2);
    chk_val("fetch strobe", 16'd14, 16'(lo + in));
    chk_val("p2 addr", 16'h0012, p2_o);
    chk_bit("p0 oe", 1'b1, p0_oe_o);
    @(posedge core_clk_i);
    core_v.ext_cycle <= 1'b0;
    core_v.ext_fetch <= 1'b0;
    wr(8'h8e, 8'h0c);
  endtask
  task automatic t_emu();
    do_reset(1'b1, 1'b0);
    chk_bit("emu mode", 1'b1, emu_o);
    chk_val("emu pins", 16'h000f, pins_o);
    chk_val("emu strobes", 16'h0005, {ale_oe_o, ale_pu_o, ps_oe_o, ps_pu_o});
    chk_bit("emu rdwr oe", 1'b0, rdwr_oe_o);
    chk_bit("emu ready", 1'b0, xmove_ready_o);
    rd(8'hf0);
    chk_bit("emu status", 1'b1, d[0]);
    do_reset(1'b0, 1'b1);
    chk_bit("emu left", 1'b0, emu_o);
    chk_val("run pins", 16'h0001, pins_o);
    chk_val("run strobes", 16'h000a, {ale_oe_o, ale_pu_o, ps_oe_o, ps_pu_o});
    chk_bit("run rdwr oe", 1'b1, rdwr_oe_o);
    ale_gap();
    chk_val("ale x2 period", 16'd3, g[15:0]);
    do_reset(1'b0, 1'b0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // the whole sequence needs well under 2000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    rst_i = 1'b1;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    double_speed_i = 1'b0;
    emu_hold = 1'b0;
    core_v = '0;
    do_reset(1'b0, 1'b0);
    t_regs();
    t_moves();
    t_ale();
    t_emu();
    summarize();
  end
endmodule
`default_nettype wire

// file: dv/abce_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module abce_mem_model (
  input  wire logic core_clk_i,
  input  wire logic emu_hold_i,
  input  wire logic ale_drv_i,
  input  wire logic ale_oe_i,
  input  wire logic ale_pu_i,
  input  wire logic prog_store_strobe_drv_i,
  input  wire logic prog_store_strobe_oe_i,
  input  wire logic prog_store_strobe_pu_i,
  output logic      ale_pin_o,
  output logic      prog_store_strobe_pin_o
);
  // ************************************************************
  // pin resolution
  // ************************************************************
  logic ale_last_r;
  logic prog_store_strobe_last_r;
  always_ff @(posedge core_clk_i) begin
    ale_last_r  <= ale_pin_o;
    prog_store_strobe_last_r <= prog_store_strobe_pin_o;
  end
  // emulator pull wins over the weak pull-up, never over a driven pin
  // an undriven pin with no pull-up must not echo its old level
  always_comb begin
    if (ale_oe_i) begin
      ale_pin_o = ale_drv_i;
    end else if (emu_hold_i) begin
      ale_pin_o = 1'b0;
    end else begin
      ale_pin_o = ale_pu_i ? 1'b1 : ~ale_last_r;
    end
    if (prog_store_strobe_oe_i) begin
      prog_store_strobe_pin_o = prog_store_strobe_drv_i;
    end else begin
      prog_store_strobe_pin_o = prog_store_strobe_pu_i ? 1'b1 : ~prog_store_strobe_last_r;
    end
  end
endmodule
`default_nettype wire
